// [inc/tlirq_consts.svh]
// constants of the top-level interrupt bookkeeping block
`ifndef TLIRQ_CONSTS_SVH
`define TLIRQ_CONSTS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define TLIRQ_NSRC        17
`define TLIRQ_ID_W        5
`define TLIRQ_DW          32
`define TLIRQ_AW          32

// ----------------------------------------------------------------------
// register offsets from the block base, and the one fixed address
// ----------------------------------------------------------------------
`define TLIRQ_OFF_ENSET   32'h0000_0100
`define TLIRQ_OFF_ENCLR   32'h0000_0180
`define TLIRQ_OFF_PSET    32'h0000_0200
`define TLIRQ_OFF_PCLR    32'h0000_0280
`define TLIRQ_OFF_ACTIVE  32'h0000_0300
`define TLIRQ_OFF_STATUS  32'h0000_0400
`define TLIRQ_OFF_MASK    32'h0000_0404
`define TLIRQ_ADR_MISSED  32'h4000_A820
`define TLIRQ_BASE_DFLT   32'h0000_0000

// ----------------------------------------------------------------------
// source bit positions
// ----------------------------------------------------------------------
`define TLIRQ_B_DEBUG     16
`define TLIRQ_B_LINE_D    15
`define TLIRQ_B_LINE_C    14
`define TLIRQ_B_LINE_B    13
`define TLIRQ_B_LINE_A    12
`define TLIRQ_B_CONV      11
`define TLIRQ_B_MAC_RX    10
`define TLIRQ_B_MAC_TX    9
`define TLIRQ_B_MAC_TMR   8
`define TLIRQ_B_SEC       7
`define TLIRQ_B_SER_TWO   6
`define TLIRQ_B_SER_ONE   5
`define TLIRQ_B_SLEEP     4
`define TLIRQ_B_BASEBAND  3
`define TLIRQ_B_MGMT      2
`define TLIRQ_B_TIM_TWO   1
`define TLIRQ_B_TIM_ONE   0

// ----------------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------------
`define TLIRQ_MISS_IMPL   17'h0FFFC
`define TLIRQ_VEC_ZERO    17'h00000
`define TLIRQ_VEC_ONE     17'h00001
`define TLIRQ_WORD_ZERO   32'h0000_0000
`define TLIRQ_PAD_ZERO    15'h0000

`endif

// [inc/tlirq_pkg.sv]
// types of the top-level interrupt bookkeeping block
`include "tlirq_consts.svh"

package tlirq_pkg;

   typedef logic [`TLIRQ_NSRC-1:0] tlirq_vec_t;

   typedef struct packed {
      logic pend;
      logic en;
      logic act;
      logic miss;
   } tlirq_cell_s;

   typedef struct packed {
      logic                  ack;
      logic [`TLIRQ_DW-1:0]  dat;
      logic                  irq;
      tlirq_vec_t            req;
      tlirq_vec_t            status;
      tlirq_vec_t            mask;
   } tlirq_core_s;

endpackage

// [logic/tlirq_cell.sv]
// one interrupt source: pending, enable, active and missed state
`timescale 1ns/100ps
`default_nettype none
`include "tlirq_consts.svh"

module tlirq_cell
   import tlirq_pkg::*;
#(
   parameter bit MISS_EN = 1'b0
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic evt,
   input  wire logic pset,
   input  wire logic pclr,
   input  wire logic eset,
   input  wire logic eclr,
   input  wire logic sstart,
   input  wire logic send,
   input  wire logic mclr,
   output logic      pend,
   output logic      en,
   output logic      act,
   output logic      miss,
   output logic      miss_pulse
);

   tlirq_cell_s s_q;
   tlirq_cell_s s_d;

   // an event while already pending is lost; the flag keeps it visible
   assign miss_pulse = MISS_EN & evt & s_q.pend;

   always_comb begin
      s_d      = s_q;
      // a new event or a software set beats a clear in the same cycle
      s_d.pend = (s_q.pend & ~pclr & ~sstart) | evt | pset;
      s_d.en   = (s_q.en | eset) & ~eclr;
      s_d.act  = (s_q.act & ~send) | sstart;
      s_d.miss = MISS_EN & ((s_q.miss & ~mclr) | miss_pulse);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign pend = s_q.pend;
   assign en   = s_q.en;
   assign act  = s_q.act;
   assign miss = s_q.miss;

endmodule
`default_nettype wire

// [logic/tlirq_core.sv]
// top-level interrupt bookkeeping with a classic Wishbone register slave
//
// Summary of operation
// - writing one to pending_clear unpends that source
// - writing zero to pending_clear changes nothing
// - fixed source bit layout, debug at 16
// - active_sources shows sources being serviced
// - event while pending sets its missed flag
// - no missed flag for debug or timers
// - reset zeroes clear, active and missed registers
// - writing one to pending_set pends that source
// - writing one to enable_clear disables that source
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "tlirq_consts.svh"

module tlirq_core
   import tlirq_pkg::*;
#(
   parameter logic [`TLIRQ_AW-1:0] BLOCK_BASE = `TLIRQ_BASE_DFLT
) (
   input  wire logic                   REF_CLK,
   input  wire logic                   SYS_RST,
   input  wire logic                   WB_CYC_I,
   input  wire logic                   WB_STB_I,
   input  wire logic                   WB_WE_I,
   input  wire logic [`TLIRQ_AW-1:0]   WB_ADR_I,
   input  wire logic [3:0]             WB_SEL_I,
   input  wire logic [`TLIRQ_DW-1:0]   WB_DAT_I,
   output logic                        WB_ACK_O,
   output logic [`TLIRQ_DW-1:0]        WB_DAT_O,
   input  wire logic [`TLIRQ_NSRC-1:0] SRC_EVENT,
   input  wire logic                   SVC_START,
   input  wire logic [`TLIRQ_ID_W-1:0] SVC_START_ID,
   input  wire logic                   SVC_END,
   input  wire logic [`TLIRQ_ID_W-1:0] SVC_END_ID,
   output logic [`TLIRQ_NSRC-1:0]      SRC_REQ,
   output logic                        IRQ_O
);

   // ----------------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------------
   localparam tlirq_vec_t MISS_IMPL = `TLIRQ_MISS_IMPL;

   tlirq_core_s          c_q;
   tlirq_core_s          c_d;
   logic                 access;
   logic                 wr;
   logic                 rd;
   logic [`TLIRQ_AW-1:0] word_adr;
   logic                 hit_enset;
   logic                 hit_enclr;
   logic                 hit_pset;
   logic                 hit_pclr;
   logic                 hit_active;
   logic                 hit_missed;
   logic                 hit_status;
   logic                 hit_mask;
   logic [`TLIRQ_DW-1:0] lane_mask;
   logic [`TLIRQ_DW-1:0] wmask_w;
   tlirq_vec_t           wmask;
   logic                 wr_enset;
   logic                 wr_enclr;
   logic                 wr_pset;
   logic                 wr_pclr;
   logic                 wr_missed;
   logic                 wr_mask;
   logic                 rd_status;
   tlirq_vec_t           start_v;
   tlirq_vec_t           end_v;
   tlirq_vec_t           pend_v;
   tlirq_vec_t           en_v;
   tlirq_vec_t           act_v;
   tlirq_vec_t           miss_v;
   tlirq_vec_t           miss_pulse_v;
   tlirq_vec_t           miss_hit;
   logic [`TLIRQ_DW-1:0] rdat;

   // one access per request; the cycle with ack high is not taken again
   assign access   = WB_CYC_I & WB_STB_I & ~c_q.ack;
   assign wr       = access & WB_WE_I;
   assign rd       = access & ~WB_WE_I;
   assign word_adr = {WB_ADR_I[`TLIRQ_AW-1:2], 2'h0};

   always_comb begin
      hit_enset  = 1'b0;
      hit_enclr  = 1'b0;
      hit_pset   = 1'b0;
      hit_pclr   = 1'b0;
      hit_active = 1'b0;
      hit_missed = 1'b0;
      hit_status = 1'b0;
      hit_mask   = 1'b0;
      if (word_adr == BLOCK_BASE + `TLIRQ_OFF_ENSET) begin
         hit_enset = 1'b1;
      end else if (word_adr == BLOCK_BASE + `TLIRQ_OFF_ENCLR) begin
         hit_enclr = 1'b1;
      end else if (word_adr == BLOCK_BASE + `TLIRQ_OFF_PSET) begin
         hit_pset = 1'b1;
      end else if (word_adr == BLOCK_BASE + `TLIRQ_OFF_PCLR) begin
         hit_pclr = 1'b1;
      end else if (word_adr == BLOCK_BASE + `TLIRQ_OFF_ACTIVE) begin
         hit_active = 1'b1;
      end else if (word_adr == `TLIRQ_ADR_MISSED) begin
         hit_missed = 1'b1;
      end else if (word_adr == BLOCK_BASE + `TLIRQ_OFF_STATUS) begin
         hit_status = 1'b1;
      end else if (word_adr == BLOCK_BASE + `TLIRQ_OFF_MASK) begin
         hit_mask = 1'b1;
      end
   end

   // unselected byte lanes write zeros, which every set or clear ignores
   assign lane_mask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                       {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
   assign wmask_w   = WB_DAT_I & lane_mask;
   assign wmask     = wmask_w[`TLIRQ_NSRC-1:0];

   assign wr_enset  = wr & hit_enset;
   assign wr_enclr  = wr & hit_enclr;
   assign wr_pset   = wr & hit_pset;
   assign wr_pclr   = wr & hit_pclr;
   assign wr_missed = wr & hit_missed;
   assign wr_mask   = wr & hit_mask;
   assign rd_status = rd & hit_status;

   // ----------------------------------------------------------------------
   // service handshake from the core
   // ----------------------------------------------------------------------
   // identifiers above the debug position are dropped
   assign start_v = (SVC_START && SVC_START_ID <= `TLIRQ_ID_W'(`TLIRQ_B_DEBUG)) ?
                    (`TLIRQ_VEC_ONE << SVC_START_ID) : `TLIRQ_VEC_ZERO;
   assign end_v   = (SVC_END && SVC_END_ID <= `TLIRQ_ID_W'(`TLIRQ_B_DEBUG)) ?
                    (`TLIRQ_VEC_ONE << SVC_END_ID) : `TLIRQ_VEC_ZERO;

   // ----------------------------------------------------------------------
   // per-source state
   // ----------------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < `TLIRQ_NSRC; i = i + 1) begin : g_src
         tlirq_cell #(
            .MISS_EN    (MISS_IMPL[i])
         ) u_cell (
            .clk        (REF_CLK),
            .rst        (SYS_RST),
            .evt        (SRC_EVENT[i]),
            .pset       (wr_pset & wmask[i]),
            .pclr       (wr_pclr & wmask[i]),
            .eset       (wr_enset & wmask[i]),
            .eclr       (wr_enclr & wmask[i]),
            .sstart     (start_v[i]),
            .send       (end_v[i]),
            .mclr       (wr_missed & wmask[i]),
            .pend       (pend_v[i]),
            .en         (en_v[i]),
            .act        (act_v[i]),
            .miss       (miss_v[i]),
            .miss_pulse (miss_pulse_v[i])
         );
      end
   endgenerate

   assign miss_hit = SRC_EVENT & pend_v & MISS_IMPL;

   // ----------------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------------
   always_comb begin
      rdat = `TLIRQ_WORD_ZERO;
      if (hit_enset || hit_enclr) begin
         rdat = {`TLIRQ_PAD_ZERO, en_v};
      end else if (hit_pset || hit_pclr) begin
         rdat = {`TLIRQ_PAD_ZERO, pend_v};
      end else if (hit_active) begin
         rdat = {`TLIRQ_PAD_ZERO, act_v};
      end else if (hit_missed) begin
         rdat = {`TLIRQ_PAD_ZERO, miss_v};
      end else if (hit_status) begin
         rdat = {`TLIRQ_PAD_ZERO, c_q.status};
      end else if (hit_mask) begin
         rdat = {`TLIRQ_PAD_ZERO, c_q.mask};
      end
   end

   // ----------------------------------------------------------------------
   // registered outputs, status and mask
   // ----------------------------------------------------------------------
   always_comb begin
      c_d     = c_q;
      c_d.ack = access;
      if (rd) begin
         c_d.dat = rdat;
      end
      // a lost event in the reading cycle survives the clear-on-read
      if (rd_status) begin
         c_d.status = miss_pulse_v;
      end else begin
         c_d.status = c_q.status | miss_pulse_v;
      end
      if (wr_mask) begin
         c_d.mask = wmask;
      end
      // one cycle behind the cell state, traded for a flopped output
      c_d.req = pend_v & en_v & ~act_v;
      c_d.irq = |(c_d.status & c_d.mask);
   end

   always_ff @(posedge REF_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         c_q <= '0;
      end else begin
         c_q <= c_d;
      end
   end

   assign WB_ACK_O = c_q.ack;
   assign WB_DAT_O = c_q.dat;
   assign SRC_REQ  = c_q.req;
   assign IRQ_O    = c_q.irq;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   property p_pclr_ones;
      @(posedge REF_CLK) disable iff (SYS_RST)
      wr_pclr |=> ((pend_v & $past(wmask) & ~$past(SRC_EVENT)) == `TLIRQ_VEC_ZERO);
   endproperty
   a_pclr_ones : assert property (p_pclr_ones)
      else $error("pending bit survived a one written to pending_clear");

   property p_pclr_zeros;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (wr_pclr && !SVC_START) |=>
         (((pend_v ^ $past(pend_v)) & ~$past(wmask) & ~$past(SRC_EVENT))
          == `TLIRQ_VEC_ZERO);
   endproperty
   a_pclr_zeros : assert property (p_pclr_zeros)
      else $error("zero written to pending_clear changed a pending bit");

   property p_debug_position;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (SRC_EVENT[`TLIRQ_B_DEBUG] && !pend_v[`TLIRQ_B_DEBUG]) |=>
         pend_v[`TLIRQ_B_DEBUG] ##1 (miss_v[`TLIRQ_B_DEBUG] == 1'b0);
   endproperty
   a_debug_position : assert property (p_debug_position)
      else $error("debug source not held at its bit position");

   property p_active_read;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (rd && hit_active) |=>
         (WB_ACK_O && WB_DAT_O == {`TLIRQ_PAD_ZERO, $past(act_v)});
   endproperty
   a_active_read : assert property (p_active_read)
      else $error("active_sources read did not return the active state");

   property p_missed_set;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (miss_hit != `TLIRQ_VEC_ZERO) |=>
         ((miss_v & $past(miss_hit)) == $past(miss_hit) &&
          (c_q.status & $past(miss_hit)) == $past(miss_hit));
   endproperty
   a_missed_set : assert property (p_missed_set)
      else $error("event on a pending source did not set its missed flag");

   property p_missed_unimpl;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (miss_v & ~MISS_IMPL) == `TLIRQ_VEC_ZERO;
   endproperty
   a_missed_unimpl : assert property (p_missed_unimpl)
      else $error("missed flag set for a source that has none");

   property p_reset_zero;
      @(posedge REF_CLK)
      $fell(SYS_RST) |->
         (pend_v == `TLIRQ_VEC_ZERO && act_v == `TLIRQ_VEC_ZERO &&
          miss_v == `TLIRQ_VEC_ZERO && !WB_ACK_O && !IRQ_O);
   endproperty
   a_reset_zero : assert property (p_reset_zero)
      else $error("state not zero after reset");

   property p_pset_ones;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (wr_pset && !SVC_START) |=>
         ((pend_v & $past(wmask)) == $past(wmask)) ##1
         (SRC_REQ == $past(pend_v & en_v & ~act_v));
   endproperty
   a_pset_ones : assert property (p_pset_ones)
      else $error("one written to pending_set did not pend the source");

   property p_enclr_ones;
      @(posedge REF_CLK) disable iff (SYS_RST)
      wr_enclr |=> ((en_v & $past(wmask)) == `TLIRQ_VEC_ZERO) ##1
         ((SRC_REQ & $past(wmask, 2)) == `TLIRQ_VEC_ZERO);
   endproperty
   a_enclr_ones : assert property (p_enclr_ones)
      else $error("one written to enable_clear left the source enabled");

   property p_missed_sticky;
      @(posedge REF_CLK) disable iff (SYS_RST)
      !wr_missed |=> (($past(miss_v) & ~miss_v) == `TLIRQ_VEC_ZERO);
   endproperty
   a_missed_sticky : assert property (p_missed_sticky)
      else $error("missed flag fell without a one written to it");

   // a status read or a mask write in the next cycle may drop the level again
   property p_irq_level;
      @(posedge REF_CLK) disable iff (SYS_RST)
      ((miss_pulse_v & c_q.mask) != `TLIRQ_VEC_ZERO && !wr_mask) |=> IRQ_O;
   endproperty
   a_irq_level : assert property (p_irq_level)
      else $error("unmasked lost event did not raise the interrupt");

   property p_missed_clear;
      @(posedge REF_CLK) disable iff (SYS_RST)
      wr_missed |=>
         ((miss_v & $past(wmask) & ~$past(miss_pulse_v)) == `TLIRQ_VEC_ZERO);
   endproperty
   a_missed_clear : assert property (p_missed_clear)
      else $error("one written to missed_events left the flag set");

   property p_start_active;
      @(posedge REF_CLK) disable iff (SYS_RST)
      (start_v != `TLIRQ_VEC_ZERO) |=>
         ((act_v & $past(start_v)) == $past(start_v));
   endproperty
   a_start_active : assert property (p_start_active)
      else $error("serviced source not shown active");

   property p_ack_pulse;
      @(posedge REF_CLK) disable iff (SYS_RST)
      access |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack_pulse : assert property (p_ack_pulse)
      else $error("bus acknowledge not a single-cycle pulse");

   property p_status_clear;
      @(posedge REF_CLK) disable iff (SYS_RST)
      rd_status |=> (c_q.status == $past(miss_pulse_v));
   endproperty
   a_status_clear : assert property (p_status_clear)
      else $error("status read did not clear the stale lost-event bits");

   property p_mask_write;
      @(posedge REF_CLK) disable iff (SYS_RST)
      wr_mask |=> (c_q.mask == $past(wmask));
   endproperty
   a_mask_write : assert property (p_mask_write)
      else $error("mask write did not land");

endmodule
`default_nettype wire

// [tb/tlirq_src_model.sv]
// behavioural model of the interrupt sources and the servicing core
`timescale 1ns/100ps
`default_nettype none
`include "tlirq_consts.svh"

module tlirq_src_model (
   input  wire logic                   clk,
   output logic [`TLIRQ_NSRC-1:0]      src_event,
   output logic                        svc_start,
   output logic [`TLIRQ_ID_W-1:0]      svc_start_id,
   output logic                        svc_end,
   output logic [`TLIRQ_ID_W-1:0]      svc_end_id
);
   initial begin
      src_event    = `TLIRQ_VEC_ZERO;
      svc_start    = 1'b0;
      svc_start_id = 5'h1F;
      svc_end      = 1'b0;
      svc_end_id   = 5'h1F;
   end

   // -------------------------------------------------------------------
   // one-cycle pulses; the trailing edge keeps calls from colliding
   // -------------------------------------------------------------------
   task automatic fire(input logic [`TLIRQ_NSRC-1:0] v);
      src_event <= v;
      @(posedge clk);
      src_event <= `TLIRQ_VEC_ZERO;
      @(posedge clk);
   endtask

   task automatic start(input logic [`TLIRQ_ID_W-1:0] id);
      svc_start    <= 1'b1;
      svc_start_id <= id;
      @(posedge clk);
      svc_start    <= 1'b0;
      // id is scrambled once idle so a stale value is never relied on
      svc_start_id <= ~id;
      @(posedge clk);
   endtask

   task automatic finish(input logic [`TLIRQ_ID_W-1:0] id);
      svc_end    <= 1'b1;
      svc_end_id <= id;
      @(posedge clk);
      svc_end    <= 1'b0;
      svc_end_id <= ~id;
      @(posedge clk);
   endtask
endmodule
`default_nettype wire

// [tb/test_top_level_irq_pend_status.sv]
// self-checking bench of the interrupt bookkeeping block
`timescale 1ns/100ps
`default_nettype none
`include "tlirq_consts.svh"

module test_top_level_irq_pend_status;
   logic                   REF_CLK;
   logic                   SYS_RST;
   logic                   WB_CYC_I;
   logic                   WB_STB_I;
   logic                   WB_WE_I;
   logic [`TLIRQ_AW-1:0]   WB_ADR_I;
   logic [3:0]             WB_SEL_I;
   logic [`TLIRQ_DW-1:0]   WB_DAT_I;
   logic                   WB_ACK_O;
   logic [`TLIRQ_DW-1:0]   WB_DAT_O;
   logic [`TLIRQ_NSRC-1:0] SRC_EVENT;
   logic                   SVC_START;
   logic [`TLIRQ_ID_W-1:0] SVC_START_ID;
   logic                   SVC_END;
   logic [`TLIRQ_ID_W-1:0] SVC_END_ID;
   logic [`TLIRQ_NSRC-1:0] SRC_REQ;
   logic                   IRQ_O;
   int                     n_mismatch;
   int                     comparisons;

   tlirq_core tlirq_core_inst (
      .REF_CLK      (REF_CLK),
      .SYS_RST      (SYS_RST),
      .WB_CYC_I     (WB_CYC_I),
      .WB_STB_I     (WB_STB_I),
      .WB_WE_I      (WB_WE_I),
      .WB_ADR_I     (WB_ADR_I),
      .WB_SEL_I     (WB_SEL_I),
      .WB_DAT_I     (WB_DAT_I),
      .WB_ACK_O     (WB_ACK_O),
      .WB_DAT_O     (WB_DAT_O),
      .SRC_EVENT    (SRC_EVENT),
      .SVC_START    (SVC_START),
      .SVC_START_ID (SVC_START_ID),
      .SVC_END      (SVC_END),
      .SVC_END_ID   (SVC_END_ID),
      .SRC_REQ      (SRC_REQ),
      .IRQ_O        (IRQ_O)
   );

   tlirq_src_model tlirq_src_model_inst (
      .clk          (REF_CLK),
      .src_event    (SRC_EVENT),
      .svc_start    (SVC_START),
      .svc_start_id (SVC_START_ID),
      .svc_end      (SVC_END),
      .svc_end_id   (SVC_END_ID)
   );

   always #5 REF_CLK = ~REF_CLK;

   // -------------------------------------------------------------------
   // compare, verdict and bus cycles
   // -------------------------------------------------------------------
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic end_of_test;
      if (n_mismatch == 0 && comparisons > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // called just after a rising edge; ack and data are taken at the rising
   // edge that sees ack high, and only the watchdog ends a wait
   task automatic wb_cycle(input logic we, input logic [31:0] a, input logic [31:0] d,
                           input logic [3:0] s, output logic [31:0] q);
      WB_CYC_I <= 1'b1;
      WB_STB_I <= 1'b1;
      WB_WE_I  <= we;
      WB_ADR_I <= a;
      WB_DAT_I <= d;
      WB_SEL_I <= s;
      do begin
         @(posedge REF_CLK);
      end while (WB_ACK_O !== 1'b1);
      q = WB_DAT_O;
      WB_CYC_I <= 1'b0;
      WB_STB_I <= 1'b0;
      // idle data is inverted so the slave cannot lean on stale lanes
      WB_DAT_I <= ~d;
      @(posedge REF_CLK);
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb_cycle(1'b1, a, d, 4'hF, q);
   endtask

   task automatic rd(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      wb_cycle(1'b0, a, 32'h0000_0000, 4'hF, q);
      check(q, exp);
   endtask

   // sel low looks at IRQ_O, high at SRC_REQ, mid-cycle where both are settled
   task automatic pin(input bit sel, input logic [31:0] exp);
      @(negedge REF_CLK);
      if (sel)
         check({15'h0, SRC_REQ}, exp);
      else
         check({31'h0, IRQ_O}, exp);
      @(posedge REF_CLK);
   endtask

   initial begin
      #200000;
      n_mismatch++;
      end_of_test;
   end

   // -------------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------------
   initial begin
      logic [31:0] q;
      REF_CLK    = 1'b0;
      SYS_RST    = 1'b1;
      WB_CYC_I   = 1'b0;
      WB_STB_I   = 1'b0;
      WB_WE_I    = 1'b0;
      WB_ADR_I   = 32'h0000_0000;
      WB_SEL_I   = 4'h0;
      WB_DAT_I   = 32'h0000_0000;
      n_mismatch  = 0;
      comparisons = 0;
      repeat (4) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      @(posedge REF_CLK);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_0000);
      rd(`TLIRQ_OFF_ACTIVE, 32'h0000_0000);
      rd(`TLIRQ_ADR_MISSED, 32'h0000_0000);
      wr(`TLIRQ_OFF_ENSET, 32'hFFFF_FFFF);
      rd(`TLIRQ_OFF_ENCLR, 32'h0001_FFFF);
      wr(`TLIRQ_OFF_ENCLR, 32'h0000_0008);
      rd(`TLIRQ_OFF_ENSET, 32'h0001_FFF7);
      wr(`TLIRQ_OFF_PSET, 32'h0001_FFFF);
      rd(`TLIRQ_OFF_PSET, 32'h0001_FFFF);
      wr(`TLIRQ_OFF_PCLR, 32'h0001_0000);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_FFFF);
      wr(`TLIRQ_OFF_PCLR, 32'h0000_0000);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_FFFF);
      wb_cycle(1'b1, `TLIRQ_OFF_PCLR, 32'h0000_F000, 4'h1, q);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_FFFF);
      wr(`TLIRQ_OFF_PCLR, 32'h0000_000F);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_FFF0);
      // only sources still pending may lose an event
      tlirq_src_model_inst.fire(17'h1FFFF);
      rd(`TLIRQ_ADR_MISSED, 32'h0000_FFF0);
      rd(`TLIRQ_OFF_PCLR, 32'h0001_FFFF);
      tlirq_src_model_inst.fire(17'h1FFFF);
      rd(`TLIRQ_ADR_MISSED, 32'h0000_FFFC);
      wr(`TLIRQ_ADR_MISSED, 32'h0000_0000);
      rd(`TLIRQ_ADR_MISSED, 32'h0000_FFFC);
      wr(`TLIRQ_ADR_MISSED, 32'hFFFF_0007);
      rd(`TLIRQ_ADR_MISSED, 32'h0000_FFF8);
      pin(1'b0, 32'h0000_0000);
      wr(`TLIRQ_OFF_MASK, 32'h0000_0004);
      pin(1'b0, 32'h0000_0001);
      rd(`TLIRQ_OFF_STATUS, 32'h0000_FFFC);
      pin(1'b0, 32'h0000_0000);
      rd(`TLIRQ_OFF_STATUS, 32'h0000_0000);
      // a fresh lost event on an unmasked source raises the level again
      tlirq_src_model_inst.fire(17'h00004);
      pin(1'b0, 32'h0000_0001);
      rd(`TLIRQ_OFF_STATUS, 32'h0000_0004);
      pin(1'b0, 32'h0000_0000);
      wr(32'h0000_0800, 32'hFFFF_FFFF);
      rd(32'h0000_0800, 32'h0000_0000);
      rd(`TLIRQ_OFF_PCLR, 32'h0001_FFFF);
      tlirq_src_model_inst.start(5'd16);
      tlirq_src_model_inst.start(5'd3);
      rd(`TLIRQ_OFF_ACTIVE, 32'h0001_0008);
      tlirq_src_model_inst.start(5'd20);
      tlirq_src_model_inst.finish(5'd16);
      rd(`TLIRQ_OFF_ACTIVE, 32'h0000_0008);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_FFF7);
      pin(1'b1, 32'h0000_FFF7);
      tlirq_src_model_inst.finish(5'd3);
      rd(`TLIRQ_OFF_ACTIVE, 32'h0000_0000);
      // reset in mid-run with pending, active and missed state all non-zero
      tlirq_src_model_inst.start(5'd5);
      SYS_RST <= 1'b1;
      repeat (2) @(posedge REF_CLK);
      SYS_RST <= 1'b0;
      @(posedge REF_CLK);
      rd(`TLIRQ_OFF_ACTIVE, 32'h0000_0000);
      rd(`TLIRQ_ADR_MISSED, 32'h0000_0000);
      rd(`TLIRQ_OFF_PCLR, 32'h0000_0000);
      pin(1'b1, 32'h0000_0000);
      end_of_test;
   end
endmodule
`default_nettype wire
